// *** msp_mode_security_power.v ***
/*
  Chip mode, security and low-power control with an APB register slave.
  Assumes straps and the external interrupt come from pins, and that the
  CPU and flash controller drive their request and status inputs on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "msp_consts.vh"

module msp_mode_security_power (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire pce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Strap pins and external wake
  input wire mode_strap_high,
  input wire mode_strap_mid,
  input wire mode_strap_low,
  input wire flash_visibility_strap,
  input wire oscillator_select_strap,
  input wire ext_irq,
  // Flash non-volatile security and erase status
  input wire nv_secured,
  input wire flash_blank,
  // CPU and debug host requests
  input wire stop_instruction,
  input wire wait_instruction,
  input wire debug_activate_cmd,
  // Chip controls
  output reg [2:0] op_mode,
  output reg flash_map_enable,
  output reg osc_colpitts,
  output reg background_debug,
  output reg debug_blocked,
  output reg osc_run,
  output reg core_clk_en,
  output reg periph_clk_en,
  output reg timer_clk_en,
  output reg cpu_halt
);

  // Raw pin levels, one bit per pin, and their synchronised copies.
  localparam integer n_pins = 6;
  wire [n_pins-1:0] pin_raw;
  wire [n_pins-1:0] pin_sync;
  wire sync_high;
  wire sync_mid;
  wire sync_low;
  wire sync_vis;
  wire sync_osc;
  wire sync_irq;
  reg strap_pending;
  reg secured;
  reg verify_busy;
  reg verify_done;
  reg [7:0] verify_cnt;
  reg pstop_sel;
  reg [1:0] pstate;

  // Mode taken from the synchronised straps, {high, mid, low}.
  wire [2:0] strap_mode = {sync_high, sync_mid, sync_low};
  wire access = psel && penable && pce;
  wire wr = access && pwrite;

  // True for every mode that drives the external bus, that is every mode
  // but the two single chip ones; used at capture and on flash map writes.
  function is_expanded;
    input [2:0] m;
    begin
      is_expanded = (m != `MSP_MODE_SSC) && (m != `MSP_MODE_NSC);
    end
  endfunction

  wire expanded = is_expanded(op_mode);

  // Word decode of the APB address, shared by every write path.
  function reg_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // Flash map per mode; unsecured decision only.
  function flash_for_mode;
    input [2:0] m;
    input vis;
    begin
      case (m)
        `MSP_MODE_SSC: flash_for_mode = 1'b1;
        `MSP_MODE_EEN: flash_for_mode = ~vis;
        `MSP_MODE_STW: flash_for_mode = 1'b0;
        `MSP_MODE_EEW: flash_for_mode = ~vis;
        `MSP_MODE_NSC: flash_for_mode = 1'b1;
        `MSP_MODE_NEN: flash_for_mode = vis;
        `MSP_MODE_NEW: flash_for_mode = vis;
        // Peripheral mode never comes from the board; flash simply stays on.
        default: flash_for_mode = 1'b1;
      endcase
    end
  endfunction

  // Mode writes allowed after reset: special modes may move anywhere except
  // peripheral; normal modes may only move among normal expanded modes.
  function mode_write_ok;
    input [2:0] from;
    input [2:0] to;
    begin
      if (to == `MSP_MODE_PER) begin
        mode_write_ok = 1'b0;
      end else if (!from[2]) begin
        mode_write_ok = 1'b1;
      end else begin
        mode_write_ok = to[2] && to[0];
      end
    end
  endfunction

  // Pins are synchronised before any logic looks at them. Only the second
  // stage of each chain is read, so a pin that moves near an edge may go
  // metastable in the first stage without reaching the mode logic.
  assign pin_raw = {ext_irq, oscillator_select_strap, flash_visibility_strap,
    mode_strap_low, mode_strap_mid, mode_strap_high};
  genvar gi;
  generate
    for (gi = 0; gi < n_pins; gi = gi + 1) begin : g_sync
      reg [1:0] chain;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chain <= 2'h0;
        end else if (pce) begin
          chain <= {chain[0], pin_raw[gi]};
        end
      end
      assign pin_sync[gi] = chain[1];
    end
  endgenerate
  assign sync_high = pin_sync[0];
  assign sync_mid = pin_sync[1];
  assign sync_low = pin_sync[2];
  assign sync_vis = pin_sync[3];
  assign sync_osc = pin_sync[4];
  assign sync_irq = pin_sync[5];

  // Straps are caught by a clocked capture once the synchronisers have
  // filled after reset release, never by the asynchronous reset itself.
  // The price is a few clocks of latency after release: the straps must
  // hold their levels until the capture edge.
  reg [1:0] rel_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_cnt <= 2'h0;
      strap_pending <= 1'b1;
    end else if (pce) begin
      if (rel_cnt != 2'h2) begin
        rel_cnt <= rel_cnt + 2'h1;
      end else begin
        strap_pending <= 1'b0;
      end
    end
  end
  wire capture = strap_pending && (rel_cnt == 2'h2);

  // Mode, flash map, oscillator, security and debug.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode <= `MSP_MODE_SSC;
      flash_map_enable <= 1'b0;
      osc_colpitts <= 1'b0;
      secured <= 1'b1;
      background_debug <= 1'b0;
      debug_blocked <= 1'b1;
      verify_busy <= 1'b0;
      verify_done <= 1'b0;
      verify_cnt <= 8'h00;
    end else if (pce) begin
      if (capture) begin
        op_mode <= strap_mode;
        osc_colpitts <= sync_osc;
        // Security is re-read from flash on every reset.
        secured <= nv_secured;
        debug_blocked <= nv_secured;
        // A secured part in an expanded mode keeps flash off the map;
        // otherwise the map follows the plain per-mode table.
        if (nv_secured && is_expanded(strap_mode)) begin
          flash_map_enable <= 1'b0;
        end else begin
          flash_map_enable <= flash_for_mode(strap_mode, sync_vis);
        end
        background_debug <= (strap_mode == `MSP_MODE_SSC) && !nv_secured;
        verify_busy <= nv_secured && flash_blank && (strap_mode == `MSP_MODE_SSC);
        verify_cnt <= 8'h00;
        verify_done <= 1'b0;
      end else begin
        // The scan checks one word a clock and gives up at the first word that
        // is not blank, leaving debug blocked until the next reset.
        if (verify_busy) begin
          if (!flash_blank) begin
            verify_busy <= 1'b0;
          end else if (verify_cnt == `MSP_VERIFY_WORDS - 8'h01) begin
            // Verified blank: debug may now reach the security bits.
            verify_busy <= 1'b0;
            verify_done <= 1'b1;
            debug_blocked <= 1'b0;
            background_debug <= 1'b1;
          end else begin
            verify_cnt <= verify_cnt + 8'h01;
          end
        end
        if (debug_activate_cmd && !debug_blocked) begin
          background_debug <= 1'b1;
        end
        if (wr && reg_hit(paddr, `MSP_OFF_MODE) && mode_write_ok(op_mode, pwdata[2:0])) begin
          op_mode <= pwdata[2:0];
        end
        if (wr && reg_hit(paddr, `MSP_OFF_MISC)) begin
          // Secured expanded parts cannot turn flash back on.
          flash_map_enable <= pwdata[`MSP_MISC_FLASH_BIT] && !(secured && expanded);
        end
      end
    end
  end

  // Low-power sequencing. A stop and a wait pulse in one cycle: stop wins,
  // as the deeper state. The wake input is a level, so it must fall before
  // the next stop or the part leaves stop one cycle after entering it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstop_sel <= 1'b0;
      pstate <= `MSP_PS_RUN;
    end else if (pce) begin
      if (wr && reg_hit(paddr, `MSP_OFF_PWR)) begin
        pstop_sel <= pwdata[`MSP_PWR_PSTOP_BIT];
      end
      case (pstate)
        `MSP_PS_RUN: begin
          if (stop_instruction) begin
            pstate <= pstop_sel ? `MSP_PS_PSTOP : `MSP_PS_STOP;
          end else if (wait_instruction) begin
            pstate <= `MSP_PS_WAIT;
          end
        end
        `MSP_PS_WAIT, `MSP_PS_PSTOP, `MSP_PS_STOP: begin
          // Only reset or the external interrupt wakes the part.
          if (sync_irq) begin
            pstate <= `MSP_PS_RUN;
          end
        end
        default: pstate <= `MSP_PS_RUN;
      endcase
    end
  end

  // Clock gates are registered so that they never glitch. They lag the state
  // by one clock; in wait the core keeps its clock and only the halt stops it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run <= 1'b1;
      core_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      timer_clk_en <= 1'b1;
      cpu_halt <= 1'b0;
    end else if (pce) begin
      osc_run <= (pstate != `MSP_PS_STOP);
      core_clk_en <= (pstate == `MSP_PS_RUN) || (pstate == `MSP_PS_WAIT);
      periph_clk_en <= (pstate == `MSP_PS_RUN) || (pstate == `MSP_PS_WAIT);
      timer_clk_en <= (pstate != `MSP_PS_STOP);
      cpu_halt <= (pstate != `MSP_PS_RUN);
    end
  end

  // Either stop flavour reads back as stopped; software tells them apart by
  // the pseudo-stop select bit it wrote itself.
  wire in_stop = (pstate == `MSP_PS_STOP) || (pstate == `MSP_PS_PSTOP);
  wire in_wait = (pstate == `MSP_PS_WAIT);

  // Read mux and error decode for the setup cycle. Unmapped addresses answer
  // with an error, and their writes fall through every decode above.
  reg [31:0] next_prdata;
  reg next_pslverr;
  always @* begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `MSP_OFF_MODE: next_prdata = {29'h0, op_mode};
      `MSP_OFF_MISC: next_prdata = {30'h0, osc_colpitts, flash_map_enable};
      `MSP_OFF_SEC: next_prdata = {28'h0, flash_blank, verify_done, verify_busy, secured};
      `MSP_OFF_PWR: next_prdata = {29'h0, in_wait, in_stop, pstop_sel};
      `MSP_OFF_DBG: next_prdata = {30'h0, debug_blocked, background_debug};
      default: next_pslverr = 1'b1;
    endcase
  end

  // APB: zero-wait answer registered from the setup cycle, so pready, prdata
  // and pslverr all stand for exactly the access cycle. pce low freezes it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (pce) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_pslverr;
      prdata <= (psel && !penable) ? next_prdata : 32'h00000000;
    end
  end

endmodule // msp_mode_security_power
`default_nettype wire

// *** msp_consts.vh ***
/*
  Constants for the mode, security and power control block: register byte
  offsets, field positions, mode codes, power states and timing counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef MSP_CONSTS_VH
`define MSP_CONSTS_VH

// Register byte offsets on the APB.
`define MSP_OFF_MODE 12'h000
`define MSP_OFF_MISC 12'h004
`define MSP_OFF_SEC 12'h008
`define MSP_OFF_PWR 12'h00c
`define MSP_OFF_DBG 12'h010

// Mode codes as {high, mid, low} strap levels.
`define MSP_MODE_SSC 3'h0
`define MSP_MODE_EEN 3'h1
`define MSP_MODE_STW 3'h2
`define MSP_MODE_EEW 3'h3
`define MSP_MODE_NSC 3'h4
`define MSP_MODE_NEN 3'h5
`define MSP_MODE_PER 3'h6
`define MSP_MODE_NEW 3'h7

// Field positions.
`define MSP_MISC_FLASH_BIT 0
`define MSP_MISC_OSC_BIT 1
`define MSP_SEC_SECURED_BIT 0
`define MSP_SEC_VERIFY_BIT 1
`define MSP_SEC_UNLOCK_BIT 2
`define MSP_SEC_ERASED_BIT 3
`define MSP_PWR_PSTOP_BIT 0
`define MSP_PWR_STOP_BIT 1
`define MSP_PWR_WAIT_BIT 2
`define MSP_DBG_ACTIVE_BIT 0
`define MSP_DBG_BLOCK_BIT 1

// Power states.
`define MSP_PS_RUN 2'h0
`define MSP_PS_WAIT 2'h1
`define MSP_PS_PSTOP 2'h2
`define MSP_PS_STOP 2'h3

// Erase-verify scan: flash words checked, one per clock.
`define MSP_VERIFY_WORDS 8'h40

`endif

// *** msp_board.sv ***
/* Board strap pins and background debug host model.
   Assumes the bench picks the strap set and times the one-cycle activation pulse. */
`timescale 1ns/1ns
`default_nettype none
module msp_board (
  // From the bench
  input wire logic [4:0] cfg,
  input wire logic act_req,
  // Pins and host command
  output logic [2:0] straps,
  output logic vis,
  output logic osc,
  output logic act_cmd
);
  // Peripheral mode would fight the external bus, so the board never straps it.
  assign straps = (cfg[4:2] == 3'h6) ? 3'h7 : cfg[4:2];
  assign vis = cfg[1];
  assign osc = cfg[0];
  assign act_cmd = act_req;
endmodule // msp_board
`default_nettype wire

// *** msp_chk.sv ***
/* Port assertions for the mode, security and power block.
   Assumes a bind to the top module, one clock and an async active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module msp_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests, APB ready and flash status
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic debug_activate_cmd,
  input wire logic nv_secured,
  input wire logic flash_blank,
  // Chip controls
  input wire logic [2:0] op_mode,
  input wire logic flash_map_enable,
  input wire logic background_debug,
  input wire logic debug_blocked,
  input wire logic osc_run,
  input wire logic core_clk_en,
  input wire logic periph_clk_en,
  input wire logic timer_clk_en,
  input wire logic cpu_halt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic seen;
  // Debug outside special single chip may only wake after a serial command.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      seen <= 1'b0;
    else if (debug_activate_cmd)
      seen <= 1'b1;
  end
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_stop_static: assert property (!osc_run |-> !core_clk_en && !periph_clk_en &&
    !timer_clk_en && cpu_halt)
    else $error("stop not static");
  a_stop_entry: assert property (stop_instruction && core_clk_en && !cpu_halt
    |-> ##[1:2] !core_clk_en)
    else $error("stop not entered");
  a_wait_entry: assert property (wait_instruction && !cpu_halt |-> ##[1:2] cpu_halt)
    else $error("wait not entered");
  a_debug_cmd: assert property ($rose(background_debug) && op_mode != 3'h0 |-> seen)
    else $error("debug woke without command");
  a_block_debug: assert property (debug_blocked |-> !background_debug)
    else $error("blocked debug active");
  a_secure_block: assert property (nv_secured && !flash_blank |-> debug_blocked)
    else $error("secured debug open");
  a_secure_flash: assert property ((nv_secured && op_mode inside {3'h1, 3'h2, 3'h3,
    3'h5, 3'h7}) [*2] |-> !flash_map_enable)
    else $error("secured flash shown");
  cover property (!osc_run);
  cover property (osc_run && !core_clk_en);
  cover property (background_debug && op_mode != 3'h0);
endmodule // msp_chk
`default_nettype wire

// *** mode_security_power_control_test.sv ***
/* Bench for the mode, security and power block: strap, APB and power sequences.
   Assumes msp_board drives the pins and msp_chk is bound at the foot. */
`timescale 1ns/1ns
`default_nettype none
`include "msp_consts.vh"
module mode_security_power_control_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, vis, osc, act_cmd, act_req = 1'b0, ext_irq = 1'b0;
  logic nv_secured = 1'b0, flash_blank = 1'b0, stop_instruction = 1'b0, wait_instruction = 1'b0;
  logic [4:0] cfg = 5'h0;
  logic [2:0] straps, op_mode;
  logic flash_map_enable, osc_colpitts, background_debug, debug_blocked;
  logic osc_run, core_clk_en, periph_clk_en, timer_clk_en, cpu_halt;
  int mismatches = 0, n_tests = 0, cyc = 0;
  msp_mode_security_power msp_mode_security_power_inst (.pclk, .presetn, .pce(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mode_strap_high(straps[2]), .mode_strap_mid(straps[1]), .mode_strap_low(straps[0]),
    .flash_visibility_strap(vis), .oscillator_select_strap(osc), .ext_irq, .nv_secured,
    .flash_blank, .stop_instruction, .wait_instruction, .debug_activate_cmd(act_cmd),
    .op_mode, .flash_map_enable, .osc_colpitts, .background_debug, .debug_blocked, .osc_run,
    .core_clk_en, .periph_clk_en, .timer_clk_en, .cpu_halt);
  msp_board msp_board_inst (.cfg, .act_req, .straps, .vis, .osc, .act_cmd);
  initial begin
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Straps must sit still until capture, so they change only inside reset.
  task automatic boot(input logic [4:0] c, input logic s);
    presetn <= 1'b0;
    cfg <= c;
    nv_secured <= s;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Wake is dropped before returning so the synchroniser cannot undo the next stop.
  task automatic lp(input logic s, input logic w, input logic irq);
    stop_instruction <= s;
    wait_instruction <= w;
    ext_irq <= irq;
    @(posedge pclk);
    stop_instruction <= 1'b0;
    wait_instruction <= 1'b0;
    repeat (5) @(posedge pclk);
    ext_irq <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic fx(input logic [2:0] m, input logic v);
    case (m)
      3'h0, 3'h4: return 1'b1;
      3'h2: return 1'b0;
      3'h1, 3'h3: return !v;
      default: return v;
    endcase
  endfunction
  initial begin
    for (int i = 0; i < 16; i++) begin
      if (i / 2 != 6) begin
        boot({i[3:0], i[1]}, 1'b0);
        ap(1'b0, `MSP_OFF_MODE, 32'h0);
        chk(q, {29'h0, i[3:1]});
        ap(1'b0, `MSP_OFF_MISC, 32'h0);
        chk(q, {30'h0, i[1], fx(i[3:1], i[0])});
        chk(background_debug, i[3:1] == 3'h0);
      end
    end
    boot(5'h10, 1'b0);
    ap(1'b0, 12'h020, 32'h0);
    chk(e, 1'b1);
    ap(1'b1, `MSP_OFF_MODE, 32'h6);
    ap(1'b0, `MSP_OFF_MODE, 32'h0);
    chk(q, 32'h4);
    ap(1'b1, `MSP_OFF_MODE, 32'h5);
    ap(1'b0, `MSP_OFF_MODE, 32'h0);
    chk(q, 32'h5);
    act_req <= 1'b1;
    @(posedge pclk);
    act_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(background_debug, 1'b1);
    lp(1'b1, 1'b0, 1'b0);
    chk({osc_run, core_clk_en, periph_clk_en, timer_clk_en, cpu_halt}, 5'h01);
    lp(1'b0, 1'b0, 1'b1);
    chk(core_clk_en, 1'b1);
    ap(1'b1, `MSP_OFF_PWR, 32'h1);
    lp(1'b1, 1'b0, 1'b0);
    chk({osc_run, core_clk_en, periph_clk_en, timer_clk_en}, 4'h9);
    ap(1'b0, `MSP_OFF_PWR, 32'h0);
    chk(q, 32'h3);
    lp(1'b0, 1'b0, 1'b1);
    lp(1'b0, 1'b1, 1'b0);
    chk({core_clk_en, periph_clk_en, timer_clk_en, cpu_halt}, 4'hf);
    lp(1'b0, 1'b0, 1'b1);
    chk(cpu_halt, 1'b0);
    boot(5'h16, 1'b1);
    ap(1'b1, `MSP_OFF_MISC, 32'h1);
    ap(1'b0, `MSP_OFF_MISC, 32'h0);
    chk({q[0], debug_blocked}, 2'h1);
    boot(5'h10, 1'b1);
    chk({flash_map_enable, debug_blocked}, 2'h3);
    flash_blank <= 1'b1;
    boot(5'h00, 1'b1);
    chk(debug_blocked, 1'b1);
    repeat (80) @(posedge pclk);
    chk({debug_blocked, background_debug}, 2'h1);
    boot(5'h16, 1'b1);
    chk(debug_blocked, 1'b1);
    conclude();
  end
endmodule // mode_security_power_control_test
bind msp_mode_security_power msp_chk msp_chk_inst (.pclk, .presetn, .psel, .penable, .pready,
  .stop_instruction, .wait_instruction, .debug_activate_cmd, .nv_secured, .flash_blank,
  .op_mode, .flash_map_enable, .background_debug, .debug_blocked, .osc_run, .core_clk_en,
  .periph_clk_en, .timer_clk_en, .cpu_halt);
`default_nettype wire
